/* hdl/adc_control_registers.sv */
// Purpose: control and result registers of a 10-bit successive approximation converter
// Assumes: inputs synchronous to clock; analog macro outside returns a sampled code
// Notes:   conversion length is modelled as a fixed count of conversion clock ticks
//
// Implementation choices: the address map and strobed register access.
`include "adc_ctrl_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: every conversion yields ten bits from selected input
// RULE2: format 0: high byte d9..d2, low d1..d0
// RULE3: format 1: high byte d9..d8, low d7..d0
// RULE4: unused result bit positions read zero
// RULE5: disabled converter powers down, results hold
// RULE6: conversion starts on start bit high-then-low
// RULE7: busy flag set at start, cleared at completion
// RULE8: software enables converter before use
// RULE9: channel codes 0..3 pick pins, others float
// RULE10: source code picks external, ground or quarter-supply
// RULE11: software deselects pins when quarter-supply chosen
// RULE12: reference code picks pin, supply or amplifier
// RULE13: software leaves reference pin unused for internal
// RULE14: conversion clock is system clock over two-power-code
// RULE15: bandgap on by enable bit or low-voltage reset
// RULE16: bandgap register unused bits read zero
// RULE17: analog pin loses digital function and pull-high
// RULE18: completion raises the converter request flag
// RULE19: software keeps conversion clock period in range
// RULE20: start taken on falling edge, fixed tick count
module adc_control_registers
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = `ADC_CONV_CYCLES  // conversion clock ticks per conversion
) (
  input  wire logic                       clock,             // 50 mhz system clock
  input  wire logic                       rstn,              // async active-low reset
  input  wire logic                       ce,                // clock enable, freezes all state
  input  wire logic [`ADC_ADDR_W-1:0]     addr,              // register address
  input  wire logic [7:0]                 wdata,             // write data
  input  wire logic                       wr,                // write strobe
  input  wire logic                       rd,                // read strobe
  output logic      [7:0]                 rdata,             // read data, cycle after rd
  input  wire logic [`ADC_RESULT_W-1:0]   sample_code,       // code from analog macro
  input  wire logic                       low_voltage_reset, // low-voltage reset enabled
  output adc_ctrl_pkg::analog_ctl_type    analog_ctl,        // analog steering
  output logic                            conv_done          // one-cycle completion pulse
);
  import adc_ctrl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ctrl_a_type                 ctrl_a;     // first control register
    ctrl_b_type                 ctrl_b;     // second control register
    logic                       bg_en;      // bandgap enable bit
    logic [`ADC_RESULT_W-1:0]   result;     // last result
    seq_state_type              state;      // sequencer
    logic [6:0]                 div_cnt;    // conversion clock prescaler
    logic [7:0]                 tick_cnt;   // conversion ticks left
    logic [7:0]                 rdata;      // read data register
    analog_ctl_type             actl;       // registered analog controls
    logic                       done;       // completion pulse
  } state_type;

  state_type s_r;    // registered state
  state_type s_nxt;  // next state
  logic      rst_n_int;  // synchronised reset
  logic      rst_meta_r; // reset sync stage one, read only by stage two
  logic      rst_sync_r; // reset sync stage two

  assign rst_n_int  = rst_sync_r;
  assign rdata      = s_r.rdata;
  assign analog_ctl = s_r.actl;
  assign conv_done  = s_r.done;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // arrange the result into the two bytes for the chosen format
  function automatic logic [15:0] pack_result(input logic fmt,
                                              input logic [`ADC_RESULT_W-1:0] d);
    if (fmt) begin
      pack_result = {6'h00, d};                  // [RULE3] [RULE4]
    end else begin
      pack_result = {d, 6'h00};                  // [RULE2] [RULE4]
    end
  endfunction

  // prescaler terminal value for a divider code: 2^code - 1
  function automatic logic [6:0] div_limit(input logic [2:0] code);
    div_limit = 7'((8'h01 << code) - 8'h01);     // [RULE14]
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  // one combinational pass builds the whole next state
  always_comb begin
    logic [15:0] res_bytes;   // aligned result
    logic        tick;        // conversion clock tick
    res_bytes = pack_result(s_r.ctrl_a.format, s_r.result);
    tick      = 1'b0;
    s_nxt     = s_r;
    s_nxt.done     = 1'b0;

    // register writes; busy is read-only so the hardware copy is kept
    if (wr) begin
      case (addr)
        `ADC_OFS_CTRL_A: begin
          s_nxt.ctrl_a      = ctrl_a_type'(wdata);
          s_nxt.ctrl_a.busy = s_r.ctrl_a.busy;
        end
        `ADC_OFS_CTRL_B: begin
          s_nxt.ctrl_b = ctrl_b_type'(wdata);
        end
        `ADC_OFS_BANDGAP: begin
          s_nxt.bg_en = wdata[`ADC_BIT_BG_EN];
        end
        default: begin
          // result registers and holes ignore writes
        end
      endcase
    end

    // read data, valid only in the cycle after the strobe
    if (rd) begin
      case (addr)
        `ADC_OFS_RES_LO:  s_nxt.rdata = res_bytes[7:0];
        `ADC_OFS_RES_HI:  s_nxt.rdata = res_bytes[15:8];
        `ADC_OFS_CTRL_A:  s_nxt.rdata = s_r.ctrl_a;
        `ADC_OFS_CTRL_B:  s_nxt.rdata = s_r.ctrl_b;
        `ADC_OFS_BANDGAP: s_nxt.rdata = {4'h0, s_r.bg_en, 3'h0};  // [RULE16]
        default:          s_nxt.rdata = 8'h00;
      endcase
    end else begin
      s_nxt.rdata = 8'h00;
    end

    // prescaler runs only during a conversion so each one starts aligned
    if (s_r.state == ST_CONV) begin
      if (s_r.div_cnt >= div_limit(s_r.ctrl_b.clk_div)) begin
        s_nxt.div_cnt = 7'h00;
        tick          = 1'b1;                    // [RULE14]
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 7'h01;
      end
    end else begin
      s_nxt.div_cnt = 7'h00;
    end

    // sequencer: start armed by a high start bit, taken when it falls
    case (s_r.state)
      ST_IDLE: begin
        if (s_r.ctrl_a.start) begin
          s_nxt.state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!s_r.ctrl_a.start) begin
          if (s_r.ctrl_a.enable) begin
            s_nxt.state       = ST_CONV;           // [RULE6] [RULE20]
            s_nxt.ctrl_a.busy = 1'b1;              // [RULE7]
            s_nxt.tick_cnt    = 8'(CONV_CYCLES);
          end else begin
            s_nxt.state = ST_IDLE;                 // powered down: no conversion
          end
        end
      end
      ST_CONV: begin
        if (!s_r.ctrl_a.enable) begin
          // switched off mid-way: abandon, result untouched
          s_nxt.state       = ST_IDLE;             // [RULE5]
          s_nxt.ctrl_a.busy = 1'b0;
        end else if (tick) begin
          if (s_r.tick_cnt <= 8'h01) begin
            s_nxt.state       = ST_IDLE;
            s_nxt.ctrl_a.busy = 1'b0;              // [RULE7]
            s_nxt.result      = sample_code;       // [RULE1]
            s_nxt.done        = 1'b1;              // [RULE18]
          end else begin
            s_nxt.tick_cnt = s_r.tick_cnt - 8'h01;
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase

    // analog steering decoded from the control registers
    s_nxt.actl             = '0;
    s_nxt.actl.power_on    = s_r.ctrl_a.enable;    // [RULE5]
    s_nxt.actl.bandgap_on  = s_r.bg_en | low_voltage_reset;  // [RULE15]
    // pins 0..3 only; higher codes leave every switch open
    if (s_r.ctrl_a.chan < 4'(`ADC_NUM_PINS)) begin
      s_nxt.actl.pin_sel[s_r.ctrl_a.chan[1:0]] = 1'b1;       // [RULE9]
    end
    // an analog pin drops its digital function and pull-high
    s_nxt.actl.pin_analog  = |s_nxt.actl.pin_sel;            // [RULE17]
    case (s_r.ctrl_b.src)
      3'h1, 3'h2, 3'h3: s_nxt.actl.sel_ground  = 1'b1;       // [RULE10]
      3'h4:             s_nxt.actl.sel_quarter = 1'b1;       // [RULE10]
      default:          s_nxt.actl.sel_ground  = 1'b0;
    endcase
    // internal sources never meet a pin, even if software forgets
    if (s_r.ctrl_b.src != 3'h0 && s_r.ctrl_b.src < 3'h5) begin
      s_nxt.actl.pin_sel    = 4'h0;                          // [RULE11]
      s_nxt.actl.pin_analog = 1'b0;
    end
    case (s_r.ctrl_b.vref)
      2'h1:    s_nxt.actl.vref_supply = 1'b1;                // [RULE12]
      2'h2:    s_nxt.actl.vref_amp    = 1'b1;                // [RULE12]
      default: s_nxt.actl.vref_pin    = 1'b1;                // [RULE12]
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // the sync stages alone see the raw reset; everything else its copy.
  // they sit outside the state struct so that each variable has one driver
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (ce) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // block state, reset by the synchronised copy
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_r.ctrl_a   <= ctrl_a_type'(`ADC_CTRL_A_RST);
      s_r.ctrl_b   <= ctrl_b_type'(`ADC_CTRL_B_RST);
      s_r.bg_en    <= 1'b0;
      s_r.result   <= `ADC_RESULT_RST;
      s_r.state    <= ST_IDLE;
      s_r.div_cnt  <= 7'h00;
      s_r.tick_cnt <= 8'h00;
      s_r.rdata    <= 8'h00;
      s_r.actl     <= '0;
      s_r.done     <= 1'b0;
    end else if (ce) begin
      s_r.ctrl_a   <= s_nxt.ctrl_a;
      s_r.ctrl_b   <= s_nxt.ctrl_b;
      s_r.bg_en    <= s_nxt.bg_en;
      s_r.result   <= s_nxt.result;
      s_r.state    <= s_nxt.state;
      s_r.div_cnt  <= s_nxt.div_cnt;
      s_r.tick_cnt <= s_nxt.tick_cnt;
      s_r.rdata    <= s_nxt.rdata;
      s_r.actl     <= s_nxt.actl;
      s_r.done     <= s_nxt.done;
    end
  end

endmodule

/* include/adc_ctrl_cfg.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide registers on a plain strobe port
// Notes:   included by the package and the design
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define ADC_ADDR_W        3
`define ADC_OFS_RES_LO    3'h0
`define ADC_OFS_RES_HI    3'h1
`define ADC_OFS_CTRL_A    3'h2
`define ADC_OFS_CTRL_B    3'h3
`define ADC_OFS_BANDGAP   3'h4
`define ADC_CTRL_A_RST    8'h00
`define ADC_CTRL_B_RST    8'h00
`define ADC_BANDGAP_RST   8'h00
`define ADC_RESULT_RST    10'h000
`define ADC_BIT_START     7
`define ADC_BIT_BUSY      6
`define ADC_BIT_ENABLE    5
`define ADC_BIT_FORMAT    4
`define ADC_BIT_BG_EN     3
`define ADC_CONV_CYCLES   14
`define ADC_NUM_PINS      4
`define ADC_RESULT_W      10

`endif

/* include/adc_ctrl_pkg.sv */
// Purpose: shared types of the converter control block
// Assumes: adc_ctrl_cfg.svh is included; field widths and state codes are literals here
// Notes:   field layouts follow the control register bit order
`include "adc_ctrl_cfg.svh"
package adc_ctrl_pkg;

  // first control register layout, msb first
  typedef struct packed {
    logic       start;
    logic       busy;
    logic       enable;
    logic       format;
    logic [3:0] chan;
  } ctrl_a_type;

  // second control register layout
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] vref;
    logic [2:0] clk_div;
  } ctrl_b_type;

  // analog steering towards the converter macro
  typedef struct packed {
    logic [3:0] pin_sel;      // one-hot analog pin switch
    logic       pin_analog;   // pin shared function and pull-high removed
    logic       sel_ground;   // ground source
    logic       sel_quarter;  // supply quarter tap source
    logic       vref_pin;     // external reference pin
    logic       vref_supply;  // converter supply as reference
    logic       vref_amp;     // amplifier output as reference
    logic       power_on;     // converter powered
    logic       bandgap_on;   // bandgap reference on
  } analog_ctl_type;

  // conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_CONV = 3'b100
  } seq_state_type;

endpackage

/* testbench/adc_control_registers_asserts.sv */
// Purpose: port-level checks of the converter register block
// Assumes: single clock domain, one-cycle read data
// Notes:   bound to the design top after the module
`include "adc_ctrl_cfg.svh"
module adc_control_registers_chk
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = 2  // ticks per conversion
) (
  input wire logic                     clock,             // system clock
  input wire logic                     rstn,              // async reset, low
  input wire logic                     ce,                // clock enable
  input wire logic [`ADC_ADDR_W-1:0]   addr,              // register address
  input wire logic [7:0]               wdata,             // write data
  input wire logic                     wr,                // write strobe
  input wire logic                     rd,                // read strobe
  input wire logic [7:0]               rdata,             // read data
  input wire logic [`ADC_RESULT_W-1:0] sample_code,       // macro code
  input wire logic                     low_voltage_reset, // lvr enabled
  input wire analog_ctl_type           analog_ctl,        // analog steering
  input wire logic                     conv_done          // completion pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // start pulse: arm write then fire write, both with the enable bit set
  sequence s_arm;
    wr && addr == `ADC_OFS_CTRL_A && wdata[`ADC_BIT_START] && wdata[`ADC_BIT_ENABLE];
  endsequence
  sequence s_fire;
    wr && addr == `ADC_OFS_CTRL_A && !wdata[`ADC_BIT_START] && wdata[`ADC_BIT_ENABLE];
  endsequence
  property p_rd_idle;
    ce && !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_bg_read;
    ce && rd && addr == `ADC_OFS_BANDGAP |=> rdata[7:4] == 4'h0 && rdata[2:0] == 3'h0;
  endproperty
  a_bg_read: assert property (p_bg_read) else $error("bandgap spare bits");
  property p_bg_lvr;
    low_voltage_reset ##1 low_voltage_reset |-> analog_ctl.bandgap_on;
  endproperty
  a_bg_lvr: assert property (p_bg_lvr) else $error("bandgap off under lvr");
  property p_pin_onehot;
    $onehot0(analog_ctl.pin_sel);
  endproperty
  a_pin_onehot: assert property (p_pin_onehot) else $error("two pins on");
  property p_internal_open;
    analog_ctl.sel_quarter || analog_ctl.sel_ground |-> analog_ctl.pin_sel == 4'h0;
  endproperty
  a_internal_open: assert property (p_internal_open) else $error("pin on internal");
  property p_vref_onehot;
    $onehot0({analog_ctl.vref_pin, analog_ctl.vref_supply, analog_ctl.vref_amp});
  endproperty
  a_vref_onehot: assert property (p_vref_onehot) else $error("two references");
  property p_analog_pin;
    analog_ctl.pin_sel != 4'h0 |-> analog_ctl.pin_analog;
  endproperty
  a_analog_pin: assert property (p_analog_pin) else $error("pin still digital");
  property p_done_power;
    conv_done |-> analog_ctl.power_on;
  endproperty
  a_done_power: assert property (p_done_power) else $error("done while off");
  property p_done_pulse;
    conv_done |=> !conv_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_busy_clear;
    conv_done && rd && addr == `ADC_OFS_CTRL_A |=> !rdata[6];
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy after done");
  property p_no_instant;
    s_arm ##[1:2] s_fire |=> !conv_done;
  endproperty
  a_no_instant: assert property (p_no_instant) else $error("done too early");
endmodule
bind adc_control_registers adc_control_registers_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sample_code(sample_code), .low_voltage_reset(low_voltage_reset),
  .analog_ctl(analog_ctl), .conv_done(conv_done));

/* testbench/tb_adc_control_registers.sv */
// Purpose: directed register-level test of the converter block
// Assumes: ce held high, short conversion count for speed
// Notes:   reads sampled 1ns after the edge that registers them
`include "adc_ctrl_cfg.svh"
module tb_adc_control_registers;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;
  localparam int CV = 2;          // shortened conversion count
  logic           clock;          // system clock
  logic           rstn;           // reset, low active
  logic           ce;             // clock enable
  logic [2:0]     addr;           // register address
  logic [7:0]     wdata;          // write data
  logic           wr;             // write strobe
  logic           rd;             // read strobe
  logic [7:0]     rdata;          // read data
  logic [9:0]     sample_code;    // macro code
  logic           low_voltage_reset; // lvr level
  analog_ctl_type analog_ctl;     // analog steering
  logic           conv_done;      // completion pulse
  logic [9:0]     last_c;         // last converted code
  int             num_errors;     // mismatches
  int             total_checks;   // comparisons
  int             cycles;         // timeout counter
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  adc_control_registers #(.CONV_CYCLES(CV)) dut (
    .clock(clock), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample_code(sample_code), .low_voltage_reset(low_voltage_reset),
    .analog_ctl(analog_ctl), .conv_done(conv_done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // strobe for one cycle, then one idle cycle so no signal is set twice
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  // one full conversion: source, reference, divider and channel from i
  task automatic conv(input int i);
    logic [7:0] d;
    logic [2:0] s;
    logic [1:0] v;
    logic [3:0] ch;
    logic [3:0] pin;
    logic       f;
    int         n;
    s = 3'(i);
    v = s[1:0];
    f = s[0];
    ch = 4'((i + 3) % 8);
    pin = (ch < 4 && (s == 0 || s > 4)) ? 4'(1 << ch) : 4'h0;
    last_c = 10'h2c6 ^ (10'(i) * 10'h051);
    sample_code <= last_c;
    wr_reg(`ADC_OFS_CTRL_B, {s, v, s});
    wr_reg(`ADC_OFS_CTRL_A, {3'b101, f, ch});
    rd_chk(`ADC_OFS_CTRL_A, {3'b101, f, ch});
    wr_reg(`ADC_OFS_CTRL_A, {3'b001, f, ch});
    #1 chk(16'({analog_ctl.pin_sel, analog_ctl.sel_ground, analog_ctl.sel_quarter,
             analog_ctl.vref_pin, analog_ctl.vref_supply, analog_ctl.vref_amp,
             analog_ctl.power_on}),
        16'({pin, s > 0 && s < 4, s == 4, v == 0 || v == 3, v == 1, v == 2, 1'b1}));
    // back onto the clock edge so the next strobe is driven right after it
    @(posedge clock);
    n = 0;
    do begin
      rd_reg(`ADC_OFS_CTRL_A, d);
      n++;
    end while (d[6] === 1'b1 && n < 400);
    chk(16'((CV << i) <= 2 * n + 2 && 2 * n <= (CV << i) + 6), 16'h0001);
    chk({8'h00, d}, {8'h00, 3'b001, f, ch});
    rd_chk(`ADC_OFS_RES_LO, f ? last_c[7:0] : {last_c[1:0], 6'h00});
    rd_chk(`ADC_OFS_RES_HI, f ? {6'h00, last_c[9:8]} : last_c[9:2]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    sample_code = 10'h000;
    low_voltage_reset = 1'b0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
    wr_reg(`ADC_OFS_CTRL_B, 8'hff);
    rd_chk(`ADC_OFS_CTRL_B, 8'hff);
    wr_reg(`ADC_OFS_CTRL_A, 8'h4f);
    rd_chk(`ADC_OFS_CTRL_A, 8'h0f);
    wr_reg(`ADC_OFS_BANDGAP, 8'hff);
    rd_chk(`ADC_OFS_BANDGAP, 8'h08);
    chk(16'(analog_ctl.bandgap_on), 16'h0001);
    wr_reg(`ADC_OFS_BANDGAP, 8'h00);
    low_voltage_reset <= 1'b1;
    repeat (3) @(posedge clock);
    chk(16'(analog_ctl.bandgap_on), 16'h0001);
    low_voltage_reset <= 1'b0;
    wr_reg(3'h5, 8'hff);
    rd_chk(3'h5, 8'h00);
    for (int i = 0; i < 8; i++) conv(i);
    // abort a slow conversion by switching the converter off
    sample_code <= 10'h155;
    wr_reg(`ADC_OFS_CTRL_B, 8'h07);
    wr_reg(`ADC_OFS_CTRL_A, 8'ha0);
    wr_reg(`ADC_OFS_CTRL_A, 8'h20);
    wr_reg(`ADC_OFS_CTRL_A, 8'h00);
    wr_reg(`ADC_OFS_CTRL_A, 8'h80);
    wr_reg(`ADC_OFS_CTRL_A, 8'h00);
    repeat (300) @(posedge clock);
    chk(16'(analog_ctl.power_on), 16'h0000);
    rd_chk(`ADC_OFS_CTRL_A, 8'h00);
    // format bit is now 0, so the held result reads left aligned
    rd_chk(`ADC_OFS_RES_LO, {last_c[1:0], 6'h00});
    rd_chk(`ADC_OFS_RES_HI, last_c[9:2]);
    report_and_stop();
  end
endmodule
